// *** logic/audio_serial_clock_div.sv ***
// Divider that makes the serial bit clock and channel clock.
`timescale 1ns/100ps
`default_nettype none

module audio_serial_clock_div (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire audio_clock_pkg::div_cfg_t cfg,
  input  wire logic                      master_audio_clock_in,
  output logic                           serial_bit_clock,
  output logic                           channel_select_clock
);

  audio_clock_pkg::div_state_t s_q;
  audio_clock_pkg::div_state_t s_d;
  logic                        in_edge;
  logic                        bit_toggle;
  logic                        bit_edge;

  // ----------------------------------------
  // Next state.
  // ----------------------------------------

  // Edges of the master input are seen at the clock rate, so the input
  // must stay below half of it.
  always_comb
  begin
    s_d        = s_q;
    s_d.in_prev = master_audio_clock_in;
    in_edge    = cfg.bit_clock_phase ?
                 (master_audio_clock_in & ~s_q.in_prev) :
                 (~master_audio_clock_in & s_q.in_prev);
    bit_toggle = 1'b0;
    if (in_edge)
    begin
      if (s_q.bit_cnt >= cfg.bit_clock_divider)
      begin
        s_d.bit_cnt = 6'h00;
        bit_toggle  = 1'b1;
      end
      else
      begin
        s_d.bit_cnt = s_q.bit_cnt + 6'h01;
      end
    end
    if (bit_toggle)
    begin
      s_d.bit_clk = ~s_q.bit_clk;
    end
    bit_edge = bit_toggle &
               (cfg.channel_clock_phase ? ~s_q.bit_clk : s_q.bit_clk);
    if (bit_edge && (cfg.channel_clock_divider != 6'h00))
    begin
      if (s_q.chan_cnt >= cfg.channel_clock_divider - 6'h01)
      begin
        s_d.chan_cnt = 6'h00;
        s_d.chan_clk = ~s_q.chan_clk;
      end
      else
      begin
        s_d.chan_cnt = s_q.chan_cnt + 6'h01;
      end
    end
  end

  // State register.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign serial_bit_clock     = s_q.bit_clk;
  assign channel_select_clock = s_q.chan_clk;

endmodule : audio_serial_clock_div

`default_nettype wire

// *** logic/field_locked_audio_clock_gen.sv ***
// Field-locked audio master clock synthesizer with AXI4-Lite registers.
`timescale 1ns/100ps
`default_nettype none

module field_locked_audio_clock_gen (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        internal_vertical,
  input  wire logic        external_vertical,
  output logic             master_audio_clock_out,
  input  wire logic        master_audio_clock_in,
  output logic             serial_bit_clock,
  output logic             channel_select_clock
);

  audio_clock_pkg::gen_state_t s_q;
  audio_clock_pkg::gen_state_t s_d;
  audio_clock_pkg::div_cfg_t   cfg;
  logic                        aw_take;
  logic                        w_take;
  logic                        ar_take;
  logic [5:0]                  ar_idx;
  logic [7:0]                  rd_val;
  logic                        rd_hit;
  logic                        wr_hit;
  logic [22:0]                 inc_eff;
  logic                        mclk_rise;
  logic                        vref;
  logic                        field_edge;

  // ----------------------------------------
  // Register bus handshakes
  // ----------------------------------------

  // Address and data are taken in either order; a new write waits for the
  // previous response to be accepted.
  assign s_axi_awready = ~s_q.aw_got & ~s_q.bvalid;
  assign s_axi_wready  = ~s_q.w_got & ~s_q.bvalid;
  assign s_axi_arready = ~s_q.rvalid;
  assign aw_take       = s_axi_awvalid & s_axi_awready;
  assign w_take        = s_axi_wvalid & s_axi_wready;
  assign ar_take       = s_axi_arvalid & s_axi_arready;
  assign ar_idx        = s_axi_araddr[7:2];

  // ----------------------------------------
  // Read decode
  // ----------------------------------------

  // Unmapped indices read as zero with an error response.
  always_comb
  begin
    rd_hit = 1'b1;
    rd_val = 8'h00;
    if (ar_idx == audio_clock_pkg::IDX_CPF_LOW)
    begin
      rd_val = s_q.cpf[7:0];
    end
    else if (ar_idx == audio_clock_pkg::IDX_CPF_MID)
    begin
      rd_val = s_q.cpf[15:8];
    end
    else if (ar_idx == audio_clock_pkg::IDX_CPF_HIGH)
    begin
      rd_val = {6'h00, s_q.cpf[17:16]};
    end
    else if (ar_idx == audio_clock_pkg::IDX_INC_LOW)
    begin
      rd_val = s_q.inc[7:0];
    end
    else if (ar_idx == audio_clock_pkg::IDX_INC_MID)
    begin
      rd_val = s_q.inc[15:8];
    end
    else if (ar_idx == audio_clock_pkg::IDX_INC_HIGH)
    begin
      rd_val = {2'h0, s_q.inc[21:16]};
    end
    else if (ar_idx == audio_clock_pkg::IDX_BIT_DIV)
    begin
      rd_val = {2'h0, s_q.bdiv};
    end
    else if (ar_idx == audio_clock_pkg::IDX_CHAN_DIV)
    begin
      rd_val = {2'h0, s_q.cdiv};
    end
    else if (ar_idx == audio_clock_pkg::IDX_CONTROL)
    begin
      rd_val = {4'h0, s_q.ctrl};
    end
    else if (ar_idx == audio_clock_pkg::IDX_STATUS)
    begin
      rd_val = {5'h00, (s_q.trim == audio_clock_pkg::TRIM_MAX) |
                       (s_q.trim == audio_clock_pkg::TRIM_MIN),
                s_q.field_seen, s_q.locked};
    end
    else
    begin
      rd_hit = 1'b0;
    end
  end

  // Write decode of the captured index; the status word is read only.
  always_comb
  begin
    wr_hit = 1'b1;
    if ((s_q.aw_idx == audio_clock_pkg::IDX_CPF_LOW) ||
        (s_q.aw_idx == audio_clock_pkg::IDX_CPF_MID) ||
        (s_q.aw_idx == audio_clock_pkg::IDX_CPF_HIGH) ||
        (s_q.aw_idx == audio_clock_pkg::IDX_INC_LOW) ||
        (s_q.aw_idx == audio_clock_pkg::IDX_INC_MID) ||
        (s_q.aw_idx == audio_clock_pkg::IDX_INC_HIGH) ||
        (s_q.aw_idx == audio_clock_pkg::IDX_BIT_DIV) ||
        (s_q.aw_idx == audio_clock_pkg::IDX_CHAN_DIV) ||
        (s_q.aw_idx == audio_clock_pkg::IDX_CONTROL))
    begin
      wr_hit = 1'b1;
    end
    else
    begin
      wr_hit = 1'b0;
    end
  end

  // ----------------------------------------
  // Synthesizer terms
  // ----------------------------------------

  // The trim is added on top of the programmed increment; with the loop
  // open it is held at zero.
  assign inc_eff = {1'b0, s_q.inc} + {{11{s_q.trim[11]}}, s_q.trim};
  assign mclk_rise = s_q.acc[22] & ~s_q.mclk_prev;
  assign vref = s_q.ctrl[audio_clock_pkg::VREF_SEL_BIT] ?
                external_vertical : internal_vertical;
  assign field_edge = vref & ~s_q.vref_prev;

  // ----------------------------------------
  // Next state
  // ----------------------------------------

  always_comb
  begin
    s_d = s_q;

    // Write channel capture.
    if (aw_take)
    begin
      s_d.aw_got = 1'b1;
      s_d.aw_idx = s_axi_awaddr[7:2];
    end
    if (w_take)
    begin
      s_d.w_got  = 1'b1;
      s_d.w_data = s_axi_wdata[7:0];
      s_d.w_en   = s_axi_wstrb[0];
    end

    // Commit a write once both halves are held.
    if (s_q.aw_got && s_q.w_got)
    begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = wr_hit ? audio_clock_pkg::RESP_OKAY :
                            audio_clock_pkg::RESP_SLVERR;
      if (s_q.w_en)
      begin
        case (s_q.aw_idx)
          audio_clock_pkg::IDX_CPF_LOW:  s_d.cpf[7:0]   = s_q.w_data;
          audio_clock_pkg::IDX_CPF_MID:  s_d.cpf[15:8]  = s_q.w_data;
          audio_clock_pkg::IDX_CPF_HIGH: s_d.cpf[17:16] = s_q.w_data[1:0];
          audio_clock_pkg::IDX_INC_LOW:  s_d.inc[7:0]   = s_q.w_data;
          audio_clock_pkg::IDX_INC_MID:  s_d.inc[15:8]  = s_q.w_data;
          audio_clock_pkg::IDX_INC_HIGH: s_d.inc[21:16] = s_q.w_data[5:0];
          audio_clock_pkg::IDX_BIT_DIV:  s_d.bdiv       = s_q.w_data[5:0];
          audio_clock_pkg::IDX_CHAN_DIV: s_d.cdiv       = s_q.w_data[5:0];
          audio_clock_pkg::IDX_CONTROL:  s_d.ctrl       = s_q.w_data[3:0];
          default: s_d.ctrl = s_q.ctrl;
        endcase
      end
    end
    else if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end

    // Read channel.
    if (ar_take)
    begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd_val;
      s_d.rresp  = rd_hit ? audio_clock_pkg::RESP_OKAY :
                            audio_clock_pkg::RESP_SLVERR;
    end
    else if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end

    // Phase accumulator, clocked by the crystal reference clock.
    s_d.acc       = s_q.acc + inc_eff;
    s_d.mclk_prev = s_q.acc[22];
    s_d.vref_prev = vref;

    // Count master clocks per field and steer the trim once per field.
    if (field_edge)
    begin
      s_d.count      = {17'h00000, mclk_rise};
      s_d.field_seen = 1'b1;
      s_d.locked     = (s_q.count == s_q.cpf);
      if (s_q.ctrl[audio_clock_pkg::LOOP_OPEN_BIT])
      begin
        s_d.trim = '0;
      end
      else if (s_q.field_seen && (s_q.count < s_q.cpf) &&
               (s_q.trim != audio_clock_pkg::TRIM_MAX))
      begin
        s_d.trim = s_q.trim + 12'sd1;
      end
      else if (s_q.field_seen && (s_q.count > s_q.cpf) &&
               (s_q.trim != audio_clock_pkg::TRIM_MIN))
      begin
        s_d.trim = s_q.trim - 12'sd1;
      end
    end
    else if (mclk_rise && (s_q.count != 18'h3ffff))
    begin
      s_d.count = s_q.count + 18'h00001;
    end

    // An open loop runs on the nominal increment alone, from the next cycle on.
    if (s_q.ctrl[audio_clock_pkg::LOOP_OPEN_BIT])
    begin
      s_d.trim = '0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q      <= '0;
      s_q.cpf  <= audio_clock_pkg::CPF_RESET;
      s_q.inc  <= audio_clock_pkg::INC_RESET;
      s_q.bdiv <= audio_clock_pkg::DIV_RESET;
      s_q.cdiv <= audio_clock_pkg::DIV_RESET;
      s_q.ctrl <= audio_clock_pkg::CONTROL_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs and serial clock divider
  // ----------------------------------------

  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp  = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp  = s_q.rresp;
  assign s_axi_rdata  = {24'h000000, s_q.rdata};
  assign master_audio_clock_out = s_q.acc[22]; // Top accumulator bit.

  // Divider configuration gathered from the registers.
  assign cfg = {s_q.bdiv,
                s_q.cdiv,
                s_q.ctrl[audio_clock_pkg::CHAN_PH_BIT],
                s_q.ctrl[audio_clock_pkg::BIT_PH_BIT]};

  audio_serial_clock_div u_div (
    .aclk                  (aclk),
    .aresetn               (aresetn),
    .cfg                   (cfg),
    .master_audio_clock_in (master_audio_clock_in),
    .serial_bit_clock      (serial_bit_clock),
    .channel_select_clock  (channel_select_clock)
  );

endmodule : field_locked_audio_clock_gen

`default_nettype wire

// *** pkg/audio_clock_pkg.sv ***
// Constants and carrier types for the field-locked audio clock generator.
`default_nettype none

package audio_clock_pkg;

  // ----------------------------------------
  // Register indices; byte address is four times the index.
  // ----------------------------------------
  localparam logic [5:0] IDX_CPF_LOW   = 6'h30;
  localparam logic [5:0] IDX_CPF_MID   = 6'h31;
  localparam logic [5:0] IDX_CPF_HIGH  = 6'h32;
  localparam logic [5:0] IDX_INC_LOW   = 6'h34;
  localparam logic [5:0] IDX_INC_MID   = 6'h35;
  localparam logic [5:0] IDX_INC_HIGH  = 6'h36;
  localparam logic [5:0] IDX_BIT_DIV   = 6'h38;
  localparam logic [5:0] IDX_CHAN_DIV  = 6'h39;
  localparam logic [5:0] IDX_CONTROL   = 6'h3a;
  localparam logic [5:0] IDX_STATUS    = 6'h3b;

  // ----------------------------------------
  // Field widths and control bit positions.
  // ----------------------------------------
  localparam int unsigned CPF_W        = 18;
  localparam int unsigned INC_W        = 22;
  localparam int unsigned ACC_W        = 23;
  localparam int unsigned DIV_W        = 6;
  localparam int unsigned TRIM_W       = 12;
  localparam int unsigned LOOP_OPEN_BIT = 3;
  localparam int unsigned VREF_SEL_BIT  = 2;
  localparam int unsigned CHAN_PH_BIT   = 1;
  localparam int unsigned BIT_PH_BIT    = 0;

  // ----------------------------------------
  // Reset values and loop limits.
  // ----------------------------------------
  localparam logic [17:0] CPF_RESET     = 18'h00000;
  localparam logic [21:0] INC_RESET     = 22'h000000;
  localparam logic [5:0]  DIV_RESET     = 6'h00;
  localparam logic [3:0]  CONTROL_RESET = 4'h0;
  localparam logic signed [11:0] TRIM_MAX = 12'sh3ff;
  localparam logic signed [11:0] TRIM_MIN = -12'sh3ff;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Configuration handed to the serial clock divider.
  typedef struct packed {
    logic [5:0] bit_clock_divider;
    logic [5:0] channel_clock_divider;
    logic       channel_clock_phase;
    logic       bit_clock_phase;
  } div_cfg_t;

  // Complete state of the serial clock divider.
  typedef struct packed {
    logic       in_prev;
    logic       bit_clk;
    logic [5:0] bit_cnt;
    logic       chan_clk;
    logic [5:0] chan_cnt;
  } div_state_t;

  // Complete state of the generator and its register slave.
  typedef struct packed {
    logic               aw_got;
    logic [5:0]         aw_idx;
    logic               w_got;
    logic [7:0]         w_data;
    logic               w_en;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [7:0]         rdata;
    logic [1:0]         rresp;
    logic [17:0]        cpf;
    logic [21:0]        inc;
    logic [5:0]         bdiv;
    logic [5:0]         cdiv;
    logic [3:0]         ctrl;
    logic [22:0]        acc;
    logic               mclk_prev;
    logic [17:0]        count;
    logic               vref_prev;
    logic signed [11:0] trim;
    logic               locked;
    logic               field_seen;
  } gen_state_t;

endpackage : audio_clock_pkg

`default_nettype wire

// *** testbench/audio_board_model.sv ***
// Board and converter side model that feeds the divider input.
`timescale 1ns/100ps
`default_nettype none

module audio_board_model (
  input  wire logic master_audio_clock_out,
  output logic      master_audio_clock_in
);
  // The standard board ties the synthesized clock straight back to the divider input.
  assign master_audio_clock_in = master_audio_clock_out;
endmodule : audio_board_model

`default_nettype wire

// *** testbench/field_locked_audio_clock_gen_assertions.sv ***
// Port-level assertions for the field-locked audio clock generator.
`timescale 1ns/100ps
`default_nettype none

module audio_clock_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        master_audio_clock_in,
  input wire logic        serial_bit_clock,
  input wire logic        channel_select_clock
);
  // All checks share the bus clock and its reset.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  property p_wr_answer;
    s_wr_take |-> ##2 s_axi_bvalid;
  endproperty
  property p_b_release;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  property p_b_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_rd_answer;
    s_rd_take |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000;
  endproperty
  property p_r_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_unmapped_rd;
    s_rd_take ##0 (s_axi_araddr == 8'h00) |=>
      s_axi_rresp == audio_clock_pkg::RESP_SLVERR && s_axi_rdata == 32'h00000000;
  endproperty
  // A bit clock move must follow a recent move of the master input.
  property p_bit_cause;
    $changed(serial_bit_clock) |->
      $past(master_audio_clock_in, 1) != $past(master_audio_clock_in, 2) ||
      $past(master_audio_clock_in, 2) != $past(master_audio_clock_in, 3);
  endproperty
  // A channel clock move must coincide with or follow a recent move of the bit clock.
  property p_chan_cause;
    $changed(channel_select_clock) |-> $changed(serial_bit_clock) ||
      $past(serial_bit_clock, 1) != $past(serial_bit_clock, 2) ||
      $past(serial_bit_clock, 2) != $past(serial_bit_clock, 3);
  endproperty

  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  a_b_release: assert property (p_b_release) else $error("write answer held");
  a_b_refuse: assert property (p_b_refuse) else $error("write taken while answering");
  a_rd_answer: assert property (p_rd_answer) else $error("read answer wrong");
  a_r_refuse: assert property (p_r_refuse) else $error("read taken while answering");
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read accepted");
  a_bit_cause: assert property (p_bit_cause) else $error("bit clock moved alone");
  a_chan_cause: assert property (p_chan_cause) else $error("channel clock moved alone");
endmodule : audio_clock_checker

bind field_locked_audio_clock_gen audio_clock_checker u_audio_clock_checker (.*);

`default_nettype wire

// *** testbench/field_locked_audio_clock_gen_tb_top.sv ***
// Self-checking bench for the field-locked audio clock generator.
`timescale 1ns/100ps
`default_nettype none

module field_locked_audio_clock_gen_tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        internal_vertical = 1'b0, external_vertical = 1'b0;
  logic        master_audio_clock_out, master_audio_clock_in;
  logic        serial_bit_clock, channel_select_clock;
  logic [31:0] lfsr_q = 32'hb414a8f8;
  int          err_count = 0, total_checks = 0, cyc = 0;
  int          model[$];
  logic [7:0]  adr [9] = '{8'hc0, 8'hc4, 8'hc8, 8'hd0, 8'hd4, 8'hd8, 8'he0, 8'he4, 8'he8};
  logic [7:0]  msk [9] = '{8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'h3f, 8'h3f, 8'h3f, 8'h0f};

  field_locked_audio_clock_gen u_field_locked_audio_clock_gen (.*);
  audio_board_model u_audio_board_model (.*);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  // Write one word; address and data are released as each is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("write response", s_axi_bresp, exp);
  endtask : wr

  // Read one word and check its response code.
  task automatic rd(input logic [7:0] a, input logic [1:0] exp, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk("read response", s_axi_rresp, exp);
  endtask : rd

  // Field starts every 400 cycles on the chosen reference.
  task automatic fields(input logic ext, input int n);
    repeat (n)
    begin
      @(posedge aclk);
      if (ext) external_vertical <= 1'b1;
      else internal_vertical <= 1'b1;
      repeat (8) @(posedge aclk);
      external_vertical <= 1'b0;
      internal_vertical <= 1'b0;
      repeat (391) @(posedge aclk);
    end
  endtask : fields

  // Returns the cycles between the last two moves of a divided clock.
  task automatic gap_of(input logic ch, output int g);
    logic p;
    int   t0;
    t0 = cyc;
    for (int k = 0; k < 3; k++)
    begin
      p = ch ? channel_select_clock : serial_bit_clock;
      do @(negedge aclk); while ((ch ? channel_select_clock : serial_bit_clock) === p);
      g = cyc - t0;
      t0 = cyc;
    end
  endtask : gap_of

  // ----------------------------------------
  // Clock, cycle count and hang guard
  // ----------------------------------------
  initial
  begin
    forever #20 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  // Main sequence: registers, field lock, master rate, dividers.
  initial
  begin
    logic [31:0] d;
    logic        p;
    int          g, sd, cd;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      wr(adr[i], lfsr_q, 2'b00);
      model.push_back(lfsr_q[7:0] & msk[i]);
    end
    for (int i = 0; i < 9; i++)
    begin
      rd(adr[i], 2'b00, d);
      chk("register readback", d, model.pop_front());
    end
    rd(8'h00, audio_clock_pkg::RESP_SLVERR, d);
    chk("unmapped read data", d, 32'h0);
    wr(8'hec, 32'h1, audio_clock_pkg::RESP_SLVERR);
    wr(8'hd8, 32'h20, 2'b00);
    wr(8'hd4, 32'h0, 2'b00);
    wr(8'hd0, 32'h0, 2'b00);
    wr(8'hc8, 32'h0, 2'b00);
    wr(8'hc4, 32'h0, 2'b00);
    wr(8'hc0, 32'h64, 2'b00);
    wr(8'he8, 32'h04, 2'b00);
    fields(1'b0, 3);
    rd(8'hec, 2'b00, d);
    chk("status on unused reference", d[1:0], 32'h0);
    fields(1'b1, 3);
    rd(8'hec, 2'b00, d);
    chk("status locked", d[2:0], 32'h3);
    wr(8'hc0, 32'h5a, 2'b00);
    fields(1'b1, 2);
    rd(8'hec, 2'b00, d);
    chk("status off target", d[2:0], 32'h2);
    wr(8'he8, 32'h08, 2'b00);
    repeat (8) @(negedge aclk);
    p = master_audio_clock_out;
    g = 0;
    repeat (400)
    begin
      @(negedge aclk);
      if (master_audio_clock_out && !p) g++;
      p = master_audio_clock_out;
    end
    chk("master clock rises", g, 100);
    wr(8'hc0, 32'h64, 2'b00);
    fields(1'b0, 2);
    rd(8'hec, 2'b00, d);
    chk("status on internal reference", d[2:0], 32'h3);
    wr(8'hd8, 32'h10, 2'b00);
    for (int k = 0; k < 4; k++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      sd = lfsr_q[1:0];
      cd = lfsr_q[3:2] + 1;
      wr(8'he0, sd, 2'b00);
      wr(8'he4, cd, 2'b00);
      wr(8'he8, 8 + k, 2'b00);
      gap_of(1'b0, g);
      chk("bit clock half period", g, (sd + 1) * 8);
      chk("bit clock edge", master_audio_clock_in, k[0]);
      gap_of(1'b1, g);
      chk("channel clock half period", g, cd * (sd + 1) * 16);
      chk("channel clock edge", serial_bit_clock, k[1]);
    end
    tally_and_finish();
  end
endmodule : field_locked_audio_clock_gen_tb_top

`default_nettype wire
